// >>> src/rwb_core.sv
// Register write, burst length set and register read engine of a serial flash.
// Assumes the 50 MHz clock oversamples cs_n, sck and io_in, all raw pins.
// Summary of operation
// [R1] Write-any-register: opcode 71h, 3 or 4 address bytes, one data byte.
// [R2] Address top bit is 23 or 31 according to the address length bit.
// [R3] Quad command mode moves instruction, address and read data on four lines.
// [R4] Register write is ignored unless the write enable latch is set.
// [R5] In-progress flag, status bit 0, stays high during a register update.
// [R6] Update failures show as program and erase error bits 6 and 5.
// [R7] Read-only bits ignore written data and raise no error.
// [R8] One-time bits only move away from default; returns ignored silently.
// [R9] Non-volatile change runs erase then program; failure keeps busy high.
// [R10] Volatile bits update at chip select rise, with no erase or program.
// [R11] Clear-status command clears error flags and returns to standby.
// [R12] Protection lock register is never written by the generic write.
// [R13] Register write frame ends like a one-byte page program: exact length.
// [R14] Burst length command changes only bits 4, 1 and 0 of config four.
// [R15] Wrapping applies only to quad I/O, DDR quad I/O and quad output reads.
// [R16] Wrap-disable set: reads run linearly until chip select rises.
// [R17] Wrap-disable clear: reads stay inside a size-aligned group.
// [R18] Wrap size codes 0 to 3 select 8, 16, 32 or 64 byte groups.
// [R19] Wrapped read starts at addressed byte, wraps to group start, repeats.
// [R20] Resets load burst settings from the non-volatile copy of config four.
// [R21] Register read repeats the same register for as long as clocked.
// [R22] Non-volatile registers sit from 00000000, volatile from 00800000.
// [R23] Burst length frame is opcode plus one byte, applied at chip select rise.
`timescale 1ns/1ps
module rwb_core #(
	parameter int TW_CYCLES = rwb_pkg::TW_CYC
) (
	// System
	input  wire logic        clock,
	input  wire logic        srst,
	// Serial link pins
	input  wire logic        cs_n,
	input  wire logic        sck,
	input  wire logic [3:0]  io_in,
	output logic      [3:0]  io_out,
	output logic      [3:0]  io_oe_n,
	// Non-volatile cell results and device resets
	input  wire logic        nv_erase_fault,
	input  wire logic        nv_program_fault,
	input  wire logic        dev_reload,
	// Array read address sequencing
	input  wire logic        rd_start,
	input  wire logic [7:0]  rd_opcode,
	input  wire logic [31:0] rd_addr,
	input  wire logic        rd_frame,
	output logic      [31:0] burst_addr,
	output logic             burst_valid,
	input  wire logic        burst_ready,
	// Status
	output logic      [7:0]  volatile_status_one,
	output logic      [7:0]  volatile_config_two,
	output logic      [7:0]  volatile_config_four,
	output logic      [7:0]  nonvolatile_config_four
);
	localparam int HALF = TW_CYCLES / 2;
	localparam int REST = TW_CYCLES - HALF;

	typedef struct packed {
		logic              cs_s1;
		logic              cs_s2;
		logic              cs_s3;
		logic              sck_s1;
		logic              sck_s2;
		logic              sck_s3;
		logic [3:0]        io_s1;
		logic [3:0]        io_s2;
		rwb_pkg::rwb_spi_e st;
		logic [7:0]        op;
		logic [31:0]       sh;
		logic [5:0]        cnt;
		logic [31:0]       addr;
		logic [7:0]        wdat;
		logic [7:0]        osh;
		logic [2:0]        ocnt;
		logic [3:0]        dout;
		logic [3:0]        oe_n;
		logic [5:0][7:0]   nv;
		logic [5:0][7:0]   vr;
		logic [7:0]        protection_lock_register;
		logic              write_enable_latch;
		logic              write_in_progress_flag;
		logic              eerr;
		logic              perr;
		rwb_pkg::rwb_eng_e eng;
		logic [31:0]       tcnt;
		logic [2:0]        pidx;
		logic [7:0]        pval;
		logic              seq_on;
		logic              seq_wrap;
		logic [31:0]       seq_addr;
		logic [7:0]        seq_mask;
	} rwb_core_s;

	rwb_core_s   r;
	rwb_core_s   n;
	logic        cs_rise;
	logic        sck_rise;
	logic        sck_fall;
	logic        quad;
	logic        alen32;
	logic [5:0]  nbits;
	logic [31:0] sh_in;
	logic [3:0]  lat;
	logic [7:0]  sr1;
	logic        a_nv;
	logic        a_vol;
	logic [2:0]  a_idx;
	logic [7:0]  rdval;
	logic [7:0]  old;
	logic [7:0]  merged;
	logic [7:0]  byte_v;
	logic        push_ok;
	logic        wel_set;

	rwb_stream_if #(.W(32)) seq_s ();

	// Keeps read-only bits, lets one-time bits leave their default only
	function automatic logic [7:0] f_merge(input logic [7:0] o, input logic [7:0] d,
		input logic [7:0] ro, input logic [7:0] otp, input logic [7:0] dflt);
		logic [7:0] moved;
		moved = o ^ dflt;
		f_merge = (o & ro) | (((moved & o) | (~moved & d)) & otp & ~ro) | (d & ~otp & ~ro); // [R7] [R8]
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Edges on the synchronised pins; a sampled edge is two clocks late
	assign cs_rise  = r.cs_s2 & ~r.cs_s3;
	assign sck_rise = r.sck_s2 & ~r.sck_s3 & ~r.cs_s2;
	assign sck_fall = ~r.sck_s2 & r.sck_s3 & ~r.cs_s2;
	assign quad     = r.vr[3][rwb_pkg::BIT_QUAD];
	assign alen32   = r.vr[3][rwb_pkg::BIT_ADDR_LEN];
	assign nbits    = r.cnt + (quad ? 6'd4 : 6'd1);
	assign sh_in    = quad ? {r.sh[27:0], r.io_s2} : {r.sh[30:0], r.io_s2[0]}; // [R3]
	assign lat      = r.vr[3][3:0];
	assign sr1      = {r.vr[0][7], r.perr, r.eerr, r.vr[0][4:2], r.write_enable_latch, r.write_in_progress_flag}; // [R5] [R6]
	assign push_ok  = seq_s.valid & seq_s.ready;
	// Enable decoded this cycle; it wins over a finishing update that clears it
	assign wel_set  = cs_rise && r.st == rwb_pkg::ST_WAITCS && r.op == rwb_pkg::OP_WR_EN;

	// Register map decode
	assign a_nv   = r.addr < (rwb_pkg::NV_BASE + 32'(rwb_pkg::NREG)); // [R22]
	assign a_vol  = r.addr >= rwb_pkg::V_BASE && r.addr < rwb_pkg::V_BASE + 32'(rwb_pkg::NREG);
	assign a_idx  = r.addr[2:0];
	assign old    = a_nv ? r.nv[a_idx] : r.vr[a_idx];
	assign merged = f_merge(old, r.wdat, rwb_pkg::RO_MASK[a_idx],
		a_nv ? rwb_pkg::OTP_MASK[a_idx] : 8'h00, rwb_pkg::NV_RST[a_idx]);

	// Read mux; undefined locations read as zero
	always_comb begin
		rdval = 8'h00;
		if (a_nv) begin
			rdval = r.nv[a_idx];
		end else if (a_vol) begin
			rdval = (a_idx == 3'd0) ? sr1 : r.vr[a_idx];
		end else if (r.addr == rwb_pkg::LOCK_ADDR) begin
			rdval = r.protection_lock_register;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		n = r;
		byte_v = (r.ocnt == 3'd0) ? rdval : r.osh; // [R21]
		n.cs_s1  = cs_n;
		n.cs_s2  = r.cs_s1;
		n.cs_s3  = r.cs_s2;
		n.sck_s1 = sck;
		n.sck_s2 = r.sck_s1;
		n.sck_s3 = r.sck_s2;
		n.io_s1  = io_in;
		n.io_s2  = r.io_s1;

		// Frame start and end
		if (r.cs_s2) begin
			n.st   = rwb_pkg::ST_IDLE;
			n.cnt  = 6'd0;
			n.ocnt = 3'd0;
			n.oe_n = 4'hf;
		end else if (r.st == rwb_pkg::ST_IDLE) begin
			n.st  = rwb_pkg::ST_CMD;
			n.cnt = 6'd0;
		end

		// Shift in on serial clock rising edges
		if (sck_rise && r.st != rwb_pkg::ST_IDLE) begin
			n.sh  = sh_in;
			n.cnt = nbits;
			case (r.st)
				rwb_pkg::ST_CMD: begin
					if (nbits == 6'd8) begin
						n.op  = sh_in[7:0];
						n.cnt = 6'd0;
						case (sh_in[7:0])
							rwb_pkg::OP_WR_EN, rwb_pkg::OP_CLR_STAT: begin
								n.st = rwb_pkg::ST_WAITCS;
							end
							rwb_pkg::OP_WR_ANY: begin
								n.st = (r.write_enable_latch && r.eng == rwb_pkg::ENG_IDLE) ?
									rwb_pkg::ST_ADDR : rwb_pkg::ST_IGN; // [R1] [R4]
							end
							rwb_pkg::OP_RD_ANY: begin
								n.st = rwb_pkg::ST_ADDR;
							end
							rwb_pkg::OP_SET_BURST: begin
								n.st = rwb_pkg::ST_WDATA; // [R23]
							end
							default: begin
								n.st = rwb_pkg::ST_IGN;
							end
						endcase
					end
				end
				rwb_pkg::ST_ADDR: begin
					if (nbits == (alen32 ? 6'd32 : 6'd24)) begin
						n.addr = alen32 ? sh_in : {8'h00, sh_in[23:0]}; // [R2]
						n.cnt  = 6'd0;
						if (r.op == rwb_pkg::OP_WR_ANY) begin
							n.st = rwb_pkg::ST_WDATA;
						end else begin
							n.st = (lat == 4'h0) ? rwb_pkg::ST_RDATA : rwb_pkg::ST_DUMMY;
						end
					end
				end
				rwb_pkg::ST_DUMMY: begin
					n.cnt = r.cnt + 6'd1;
					if (r.cnt + 6'd1 == {2'b00, lat}) begin
						n.st = rwb_pkg::ST_RDATA;
					end
				end
				rwb_pkg::ST_WDATA: begin
					if (nbits == 6'd8) begin
						n.wdat = sh_in[7:0];
						n.st   = rwb_pkg::ST_WAITCS;
					end
				end
				rwb_pkg::ST_WAITCS: begin
					n.st = rwb_pkg::ST_IGN; // [R13]
				end
				default: begin
				end
			endcase
		end

		// Drive read data on falling edges, same register every byte
		if (sck_fall && r.st == rwb_pkg::ST_RDATA) begin
			if (quad) begin
				n.dout = byte_v[7:4]; // [R3]
				n.osh  = {byte_v[3:0], 4'h0};
				n.ocnt = r.ocnt + 3'd4;
				n.oe_n = 4'h0;
			end else begin
				n.dout = {2'b00, byte_v[7], 1'b0};
				n.osh  = {byte_v[6:0], 1'b0};
				n.ocnt = r.ocnt + 3'd1;
				n.oe_n = 4'b1101;
			end
		end

		// Commands take effect only when chip select rises on a whole frame
		if (cs_rise && r.st == rwb_pkg::ST_WAITCS) begin
			case (r.op)
				rwb_pkg::OP_WR_EN: begin
					n.write_enable_latch = 1'b1;
				end
				rwb_pkg::OP_CLR_STAT: begin
					if (r.eng == rwb_pkg::ENG_IDLE || r.eng == rwb_pkg::ENG_FAIL) begin
						n.eerr = 1'b0; // [R11]
						n.perr = 1'b0;
						n.write_in_progress_flag  = 1'b0;
						n.write_enable_latch  = 1'b0;
						n.eng  = rwb_pkg::ENG_IDLE;
					end
				end
				rwb_pkg::OP_SET_BURST: begin
					n.vr[5] = (r.vr[5] & ~rwb_pkg::BURST_MASK) |
						(r.wdat & rwb_pkg::BURST_MASK); // [R14] [R23]
				end
				rwb_pkg::OP_WR_ANY: begin
					n.write_enable_latch = 1'b0;
					// Lock register address matches neither region: refused
					if (a_vol) begin
						n.vr[a_idx] = merged; // [R10] [R12]
					end else if (a_nv && merged != old) begin
						n.write_enable_latch  = 1'b1; // [R9]
						n.write_in_progress_flag  = 1'b1; // [R5]
						n.eng  = rwb_pkg::ENG_ERASE;
						n.tcnt = 32'd0;
						n.pidx = a_idx;
						n.pval = merged;
					end
				end
				default: begin
				end
			endcase
		end

		// Erase half then program half of the non-volatile write time
		case (r.eng)
			rwb_pkg::ENG_ERASE: begin
				n.tcnt = r.tcnt + 32'd1;
				if (r.tcnt == 32'(HALF - 1)) begin
					n.tcnt = 32'd0;
					if (nv_erase_fault) begin
						n.eerr = 1'b1; // [R6] [R9]
						n.eng  = rwb_pkg::ENG_FAIL;
					end else begin
						n.eng = rwb_pkg::ENG_PROG;
					end
				end
			end
			rwb_pkg::ENG_PROG: begin
				n.tcnt = r.tcnt + 32'd1;
				if (r.tcnt == 32'(REST - 1)) begin
					if (nv_program_fault) begin
						n.perr = 1'b1; // [R6] [R9]
						n.eng  = rwb_pkg::ENG_FAIL;
					end else begin
						n.nv[r.pidx] = r.pval;
						n.write_in_progress_flag = 1'b0;
						n.write_enable_latch = wel_set;
						n.eng = rwb_pkg::ENG_IDLE;
					end
				end
			end
			default: begin
			end
		endcase

		// Hardware or software reset reloads volatile copies; frame dropped
		if (dev_reload) begin
			n.vr  = r.nv & ~rwb_pkg::RO_MASK; // [R20]
			n.write_enable_latch = 1'b0;
			n.st  = rwb_pkg::ST_IGN;
		end

		// Array read address sequencer; start wins over frame end
		if (rd_start) begin
			n.seq_on   = 1'b1;
			n.seq_addr = rd_addr;
			n.seq_mask = rwb_pkg::WRAP_MASK[r.vr[5][1:0]]; // [R18]
			n.seq_wrap = ~r.vr[5][rwb_pkg::BIT_WRAP_OFF] &&
				(rd_opcode == rwb_pkg::OP_QUAD_OUT || rd_opcode == rwb_pkg::OP_QUAD_IO ||
				rd_opcode == rwb_pkg::OP_QUAD_IO_DDR); // [R15] [R16]
		end else if (!rd_frame) begin
			n.seq_on = 1'b0;
		end else if (push_ok) begin
			n.seq_addr = r.seq_wrap ?
				((r.seq_addr & ~{24'h0, r.seq_mask}) |
				((r.seq_addr + 32'd1) & {24'h0, r.seq_mask})) : // [R17] [R19]
				r.seq_addr + 32'd1;
		end
	end

	// State register; power-on state loads the non-volatile defaults
	always_ff @(posedge clock) begin
		if (srst) begin
			r       <= '0;
			r.cs_s1 <= 1'b1;
			r.cs_s2 <= 1'b1;
			r.cs_s3 <= 1'b1;
			r.oe_n  <= 4'hf;
			r.nv    <= rwb_pkg::NV_RST;
			r.vr    <= rwb_pkg::VR_RST; // [R20]
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Address stream through the two-entry buffer; receiver stall holds it
	assign seq_s.valid = r.seq_on & rd_frame;
	assign seq_s.data  = r.seq_addr;

	rwb_pair_buf #(.W(32), .DEPTH(2)) u_buf (
		.clock     (clock),
		.srst      (srst),
		.in_s      (seq_s),
		.out_data  (burst_addr),
		.out_valid (burst_valid),
		.out_ready (burst_ready)
	);

	// Outputs
	assign io_out                  = r.dout;
	assign io_oe_n                 = r.oe_n;
	assign volatile_status_one     = sr1;
	assign volatile_config_two     = r.vr[3];
	assign volatile_config_four    = r.vr[5];
	assign nonvolatile_config_four = r.nv[5];

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	sequence s_nv_start;
		r.eng == rwb_pkg::ENG_IDLE ##1 r.eng == rwb_pkg::ENG_ERASE;
	endsequence
	sequence s_burst_cmd;
		cs_rise && r.st == rwb_pkg::ST_WAITCS && r.op == rwb_pkg::OP_SET_BURST && !dev_reload;
	endsequence
	sequence s_seq_step;
		push_ok && !rd_start && rd_frame;
	endsequence

	property p_wel_gate;
		s_nv_start |-> $past(r.write_enable_latch);
	endproperty
	a_wel_gate: assert property (p_wel_gate) else $error("update began without enable"); // [R4]
	property p_busy_hold;
		s_nv_start |-> r.write_in_progress_flag [*8];
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy flag dropped early"); // [R5]
	property p_fail_flag;
		r.eng == rwb_pkg::ENG_FAIL |-> r.write_in_progress_flag && (r.eerr || r.perr);
	endproperty
	a_fail_flag: assert property (p_fail_flag) else $error("failure without flags"); // [R9]
	property p_burst_bits;
		s_burst_cmd |=> ((r.vr[5] & ~rwb_pkg::BURST_MASK) == $past(r.vr[5] & ~rwb_pkg::BURST_MASK))
			&& (r.vr[5][4] == $past(r.wdat[4]));
	endproperty
	a_burst_bits: assert property (p_burst_bits) else $error("burst command bits wrong"); // [R14]
	property p_lock_fixed;
		##1 $stable(r.protection_lock_register);
	endproperty
	a_lock_fixed: assert property (p_lock_fixed) else $error("lock register changed"); // [R12]
	property p_clear;
		(cs_rise && r.st == rwb_pkg::ST_WAITCS && r.op == rwb_pkg::OP_CLR_STAT &&
			r.eng == rwb_pkg::ENG_FAIL) |=> !r.perr && !r.eerr && r.eng == rwb_pkg::ENG_IDLE;
	endproperty
	a_clear: assert property (p_clear) else $error("clear status failed"); // [R11]
	property p_wrap_group;
		s_seq_step and r.seq_wrap |=>
			((r.seq_addr ^ $past(r.seq_addr)) & ~{24'h0, r.seq_mask}) == 32'h0;
	endproperty
	a_wrap_group: assert property (p_wrap_group) else $error("wrap left its group"); // [R17]
	property p_linear;
		s_seq_step and !r.seq_wrap |=> r.seq_addr == $past(r.seq_addr) + 32'h1;
	endproperty
	a_linear: assert property (p_linear) else $error("linear read skipped"); // [R16]
	property p_wrap_size;
		rd_start && r.vr[5][1:0] == 2'b11 |=> r.seq_mask == 8'h3f;
	endproperty
	a_wrap_size: assert property (p_wrap_size) else $error("wrap size wrong"); // [R18]
	property p_wrap_return;
		s_seq_step and r.seq_wrap && r.seq_mask == 8'h07 && r.seq_addr[2:0] == 3'h7
			|=> r.seq_addr[2:0] == 3'h0;
	endproperty
	a_wrap_return: assert property (p_wrap_return) else $error("no wrap to start"); // [R19]

endmodule // rwb_core

// >>> src/rwb_pair_buf.sv
// Small valid/ready FIFO, two entries by default.
// Assumes synchronous active-high reset on the same clock as both sides.
`timescale 1ns/1ps
module rwb_pair_buf #(
	parameter int W     = 32,
	parameter int DEPTH = 2
) (
	// System
	input  wire logic         clock,
	input  wire logic         srst,
	// Fill side
	rwb_stream_if.snk         in_s,
	// Drain side
	output logic      [W-1:0] out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} rwb_buf_s;

	rwb_buf_s r;
	rwb_buf_s n;
	logic     push;
	logic     pop;

	////////////////////////////////////////////////////////////////////////////
	// Handshakes: full stalls the source, empty hides stale data
	assign in_s.ready = r.cnt < (AW+1)'(DEPTH);
	assign out_valid  = r.cnt != '0;
	assign out_data   = r.mem[r.rp];
	assign push       = in_s.valid & in_s.ready;
	assign pop        = out_valid & out_ready;

	// Next state
	always_comb begin
		n = r;
		if (push) begin
			n.mem[r.wp] = in_s.data;
			n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + AW'(1);
		end
		if (pop) begin
			n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + AW'(1);
		end
		n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	// State register
	always_ff @(posedge clock) begin
		if (srst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

endmodule // rwb_pair_buf

// >>> src/rwb_pkg.sv
// Constants shared by the register write / burst wrap engine and its bench.
// Assumes a single 50 MHz system clock that oversamples the serial link.
package rwb_pkg;

	// Instruction codes
	localparam logic [7:0] OP_WR_EN       = 8'h06;
	localparam logic [7:0] OP_CLR_STAT    = 8'h30;
	localparam logic [7:0] OP_WR_ANY      = 8'h71;
	localparam logic [7:0] OP_RD_ANY      = 8'h65;
	localparam logic [7:0] OP_SET_BURST   = 8'hc0;
	localparam logic [7:0] OP_QUAD_OUT    = 8'h6b;
	localparam logic [7:0] OP_QUAD_IO     = 8'heb;
	localparam logic [7:0] OP_QUAD_IO_DDR = 8'hed;

	// Register map
	localparam int          NREG      = 6;
	localparam logic [31:0] NV_BASE   = 32'h0000_0000;
	localparam logic [31:0] V_BASE    = 32'h0080_0000;
	localparam logic [31:0] LOCK_ADDR = 32'h0080_0040;

	// Field positions
	localparam int BIT_IN_PROG   = 0;
	localparam int BIT_WR_LATCH  = 1;
	localparam int BIT_ERASE_ERR = 5;
	localparam int BIT_PROG_ERR  = 6;
	localparam int BIT_QUAD      = 6;
	localparam int BIT_ADDR_LEN  = 7;
	localparam int BIT_WRAP_OFF  = 4;
	localparam logic [7:0] BURST_MASK = 8'h13;

	// Per register defaults and bit kinds, index 5 first
	localparam logic [5:0][7:0] NV_RST   = {8'h10, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00};
	localparam logic [5:0][7:0] RO_MASK  = {8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h63};
	localparam logic [5:0][7:0] OTP_MASK = {8'h00, 8'h00, 8'h00, 8'h3c, 8'h00, 8'h00};
	localparam logic [5:0][7:0] VR_RST   = NV_RST & ~RO_MASK;

	// Wrap group masks for size codes 3..0
	localparam logic [3:0][7:0] WRAP_MASK = {8'h3f, 8'h1f, 8'h0f, 8'h07};

	// Non-volatile register write time
	localparam int CLK_MHZ = 50;
	localparam int TW_US   = 500;
	localparam int TW_CYC  = TW_US * CLK_MHZ;

	// Frame decoder states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_CMD    = 3'b001,
		ST_ADDR   = 3'b010,
		ST_DUMMY  = 3'b011,
		ST_RDATA  = 3'b100,
		ST_WDATA  = 3'b101,
		ST_WAITCS = 3'b110,
		ST_IGN    = 3'b111
	} rwb_spi_e;

	// Non-volatile update engine states
	typedef enum logic [1:0] {
		ENG_IDLE  = 2'b00,
		ENG_ERASE = 2'b01,
		ENG_PROG  = 2'b10,
		ENG_FAIL  = 2'b11
	} rwb_eng_e;

endpackage

// >>> src/rwb_stream_if.sv
// Valid/ready word stream between the engine and its buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rwb_stream_if #(parameter int W = 32);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// >>> verification/rwb_core_tb.sv
// Self-checking bench for the register write / burst wrap engine.
// Assumes the host model drives the link and the bench the read stream.
`timescale 1ns/1ps
module rwb_core_tb;
////////////////////////////////////////////////////////////////////////////////
	// Short write time keeps the run brief
	localparam int TW = 40;
	logic        clock          = 1'b0;
	logic        srst           = 1'b1;
	logic        cs_n;
	logic        sck;
	logic [3:0]  io_in;
	logic [3:0]  io_out;
	logic [3:0]  io_oe_n;
	logic        nv_erase_fault   = 1'b0;
	logic        nv_program_fault = 1'b0;
	logic        dev_reload     = 1'b0;
	logic        rd_start       = 1'b0;
	logic [7:0]  rd_opcode      = 8'h00;
	logic [31:0] rd_addr        = 32'h0;
	logic        rd_frame       = 1'b0;
	logic [31:0] burst_addr;
	logic        burst_valid;
	logic        burst_ready    = 1'b0;
	logic [7:0]  sr1;
	logic [7:0]  cfg2;
	logic [7:0]  cfg4;
	logic [7:0]  nv4;
	logic [15:0] rd;
	logic        host_quad      = 1'b0;
	int          na             = 3;
	int          cyc            = 0;
	int          n_mismatch     = 0;
	int          checks_done    = 0;

	always #10 clock = ~clock;

	rwb_core #(.TW_CYCLES(TW)) rwb_core_inst (
		.clock(clock), .srst(srst), .cs_n(cs_n), .sck(sck), .io_in(io_in),
		.io_out(io_out), .io_oe_n(io_oe_n), .nv_erase_fault(nv_erase_fault),
		.nv_program_fault(nv_program_fault), .dev_reload(dev_reload),
		.rd_start(rd_start), .rd_opcode(rd_opcode), .rd_addr(rd_addr),
		.rd_frame(rd_frame), .burst_addr(burst_addr), .burst_valid(burst_valid),
		.burst_ready(burst_ready), .volatile_status_one(sr1),
		.volatile_config_two(cfg2), .volatile_config_four(cfg4),
		.nonvolatile_config_four(nv4));

	rwb_host_model host_inst (
		.clock(clock), .cs_n(cs_n), .sck(sck), .io_in(io_in), .io_out(io_out),
		.io_oe_n(io_oe_n), .quad(host_quad));

////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t addr got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// Opcode-only frame
	task automatic op1(input logic [7:0] op);
		host_inst.frame(op, 0, 32'h0, 0, 8'h00, 0, 0, rd);
	endtask

	// Register write frame with the current address length
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		host_inst.frame(rwb_pkg::OP_WR_ANY, na, a, 1, d, 0, 0, rd);
	endtask

	// Stalling consumer: each word after the first is held two cycles before it is taken
	task automatic stream(input logic [7:0] op, input logic [31:0] a0,
		input logic [31:0] m, input int n);
		int i;
		int k;
		rd_opcode = op;
		rd_addr   = a0;
		rd_frame  = 1'b1;
		rd_start  = 1'b1;
		tick(1);
		rd_start  = 1'b0;
		for (i = 0; i < n; i++) begin
			k = 0;
			while (burst_valid !== 1'b1 && k < 50) begin
				tick(1);
				k++;
			end
			chk32(burst_addr, (a0 & ~m) | ((a0 + i) & m));
			burst_ready = 1'b1;
			tick(1);
			burst_ready = 1'b0;
			tick(2);
		end
		rd_frame    = 1'b0;
		burst_ready = 1'b1;
		tick(6);
		burst_ready = 1'b0;
	endtask

	// Hang guard
	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			end_of_test();
		end
	end

////////////////////////////////////////////////////////////////////////////////
	initial begin
		int k;
		int f;
		tick(6);
		srst = 1'b0;
		tick(4);
		chk(sr1, 8'h00);
		chk(cfg2, 8'h08);
		chk(cfg4, 8'h10);
		chk(nv4, 8'h10);
		// Wrap disabled out of reset: a quad read runs linearly
		stream(rwb_pkg::OP_QUAD_IO, 32'h0000_101e, 32'hffff_ffff, 4);
		// Write without the enable latch is dropped
		wr(32'h0080_0005, 8'h03);
		chk(cfg4, 8'h10);
		op1(rwb_pkg::OP_WR_EN);
		wr(32'h0080_0005, 8'h03);
		chk(cfg4, 8'h03);
		chk(sr1, 8'h00);
		host_inst.frame(rwb_pkg::OP_SET_BURST, 0, 32'h0, 1, 8'he2, 0, 0, rd);
		chk(cfg4, 8'h02);
		host_inst.frame(rwb_pkg::OP_RD_ANY, 3, 32'h0080_0005, 0, 8'h00, 8, 16, rd);
		chk(rd[15:8], 8'h02);
		chk(rd[7:0], 8'h02);
		// Wrap in 32-byte groups, then linear for a non-wrapping read
		stream(rwb_pkg::OP_QUAD_IO, 32'h0000_101e, 32'h1f, 34);
		stream(rwb_pkg::OP_QUAD_OUT, 32'h0000_101e, 32'h1f, 4);
		stream(rwb_pkg::OP_QUAD_IO_DDR, 32'h0000_101e, 32'h1f, 4);
		stream(8'h0b, 32'h0000_101e, 32'hffff_ffff, 4);
		// Lock register refuses the generic write
		op1(rwb_pkg::OP_WR_EN);
		wr(rwb_pkg::LOCK_ADDR, 8'hff);
		chk(sr1, 8'h00);
		// Non-volatile copy update runs busy
		op1(rwb_pkg::OP_WR_EN);
		wr(32'h0000_0005, 8'h00);
		chk(sr1, 8'h03);
		k = 0;
		while (sr1[0] !== 1'b0 && k < 200) begin
			tick(1);
			k++;
		end
		chk(sr1, 8'h00);
		chk(nv4, 8'h00);
		chk(cfg4, 8'h02);
		dev_reload = 1'b1;
		tick(1);
		dev_reload = 1'b0;
		tick(2);
		chk(cfg4, 8'h00);
		// Smallest and largest groups
		stream(rwb_pkg::OP_QUAD_OUT, 32'h0000_2007, 32'h7, 10);
		host_inst.frame(rwb_pkg::OP_SET_BURST, 0, 32'h0, 1, 8'he3, 0, 0, rd);
		chk(cfg4, 8'h03);
		stream(rwb_pkg::OP_QUAD_IO, 32'h0000_203d, 32'h3f, 6);
		// Erase fault, then program fault, each cleared by clear-status
		for (f = 0; f < 2; f++) begin
			nv_erase_fault   = (f == 0);
			nv_program_fault = (f == 1);
			op1(rwb_pkg::OP_WR_EN);
			wr(32'h0000_0005, 8'h10);
			k = 0;
			while (sr1[6:5] === 2'b00 && k < 200) begin
				tick(1);
				k++;
			end
			tick(2);
			chk(sr1 & 8'h61, (f == 0) ? 8'h21 : 8'h41);
			nv_erase_fault   = 1'b0;
			nv_program_fault = 1'b0;
			op1(rwb_pkg::OP_CLR_STAT);
			chk(sr1 & 8'h61, 8'h00);
		end
		// Quad command mode: every phase on four lines
		op1(rwb_pkg::OP_WR_EN);
		wr(32'h0080_0003, 8'h48);
		chk(cfg2, 8'h48);
		host_quad = 1'b1;
		host_inst.frame(rwb_pkg::OP_RD_ANY, 3, 32'h0080_0003, 0, 8'h00, 8, 4, rd);
		chk(rd[15:8], 8'h48);
		chk(rd[7:0], 8'h48);
		op1(rwb_pkg::OP_WR_EN);
		wr(32'h0080_0003, 8'h08);
		host_quad = 1'b0;
		chk(cfg2, 8'h08);
		// Four-byte address mode
		op1(rwb_pkg::OP_WR_EN);
		wr(32'h0080_0003, 8'h88);
		chk(cfg2, 8'h88);
		na = 4;
		op1(rwb_pkg::OP_WR_EN);
		wr(32'h0080_0005, 8'h11);
		chk(cfg4, 8'h11);
		end_of_test();
	end
endmodule // rwb_core_tb

// >>> verification/rwb_host_model.sv
// Host-side serial link driver for the register write / burst engine.
// Assumes clock parked low, 4-clock half period, one or four data lines.
`timescale 1ns/1ps
module rwb_host_model (
	// System
	input  wire logic       clock,
	// Link pins
	output logic            cs_n,
	output logic            sck,
	output logic      [3:0] io_in,
	input  wire logic [3:0] io_out,
	input  wire logic [3:0] io_oe_n,
	// Four lines a clock when set
	input  wire logic       quad
);
////////////////////////////////////////////////////////////////////////////////
	// Idle link: deselected, clock standing still
	initial begin
		cs_n  = 1'b1;
		sck   = 1'b0;
		io_in = 4'h0;
	end

	// Step just past a clock edge
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// One clock: drive while low, sample just before the rise;
	// an undriven line reads inverted, so a missing enable shows
	task automatic bit_cyc(input logic [3:0] din, output logic [3:0] dout);
		io_in = quad ? din : {io_in[3:1], din[0]};
		tick(4);
		dout = io_out ^ io_oe_n;
		sck = 1'b1;
		tick(4);
		sck = 1'b0;
	endtask

	// Top nb bits of w, most significant first, one or four a clock
	task automatic send(input logic [31:0] w, input int nb);
		logic [31:0] v;
		logic [3:0]  b;
		int          i;
		v = w;
		for (i = 0; i < nb; i += (quad ? 4 : 1)) begin
			bit_cyc(quad ? v[31:28] : {3'b000, v[31]}, b);
			v = quad ? v << 4 : v << 1;
		end
	endtask

	// Whole frame; bytes and address go most significant bit first
	task automatic frame(input logic [7:0] op, input int na, input logic [31:0] adr,
		input int nw, input logic [7:0] dat, input int ndm, input int nrd,
		output logic [15:0] rd);
		logic [3:0] b;
		int         i;
		rd   = 16'h0;
		cs_n = 1'b0;
		tick(4);
		send({op, 24'h0}, 8);
		send(adr << (32 - na * 8), na * 8);
		send({dat, 24'h0}, nw * 8);
		for (i = 0; i < ndm; i++) bit_cyc(~io_in, b);
		for (i = 0; i < nrd; i++) begin
			bit_cyc(~io_in, b);
			rd = quad ? {rd[11:0], b} : {rd[14:0], b[1]};
		end
		tick(4);
		cs_n = 1'b1;
		// Released line must not show stale data
		io_in = ~io_in;
		tick(10);
	endtask
endmodule // rwb_host_model
